// file: pkg/spx_defs.svh
// Constants of the serial port block: offsets, fields, reset values.
// Assumes inclusion by the package, by the design files and by the bench.
`ifndef SPX_DEFS_SVH
`define SPX_DEFS_SVH

// ------------------------------------------------------------
// Register byte offsets on the APB port.
// ------------------------------------------------------------
`define SPX_OFS_STATUS 8'h00
`define SPX_OFS_RX 8'h04
`define SPX_OFS_TX 8'h08
`define SPX_OFS_DIV 8'h0C
`define SPX_OFS_CTRL 8'h10

// ------------------------------------------------------------
// Reset values and the idle fill byte.
// ------------------------------------------------------------
`define SPX_CTRL_RST 16'h0000
`define SPX_DIV_RST 8'h00
`define SPX_FILL_ZERO 8'h00

// ------------------------------------------------------------
// Field positions inside the status word.
// ------------------------------------------------------------
`define SPX_ST_IRQ 0
`define SPX_ST_TXC_LO 1
`define SPX_ST_TXUF 4
`define SPX_ST_TXIRQ 5
`define SPX_ST_RXIRQ 6
`define SPX_ST_OVF 7
`define SPX_ST_RXC_LO 8
`define SPX_ST_EXCESS 11

// ------------------------------------------------------------
// Sizes and bit counts.
// ------------------------------------------------------------
`define SPX_FIFO_DEPTH 3'h4
`define SPX_LAST_BIT 3'h7

`endif

// file: pkg/spx_pkg.sv
// Types shared by the serial port block.
// Assumes the constant header is reachable on the include path.
`include "spx_defs.svh"

package spx_pkg;

  // Control word, most significant field first.
  typedef struct packed {
    logic [1:0] irq_threshold_sel;    // Threshold code, count is code+1.
    logic tx_queue_purge;             // Flush and hold the transmit queue.
    logic rx_queue_purge;             // Flush and hold the receive queue.
    logic back_to_back_xfer;          // Keep select low across bytes.
    logic internal_loopback_en;       // Feed own output into receiver.
    logic miso_drive_en;              // Push-pull MISO when set.
    logic rx_overrun_replace;         // Overwrite newest byte on overrun.
    logic idle_zero_fill;             // Send zero when queue is empty.
    logic xfer_trigger_sel;           // 1: start on write, 0: on read.
    logic lsb_first;                  // Held only, not used here.
    logic wired_or;                   // Held only, not used here.
    logic clk_idle_high;              // Serial clock idle level.
    logic clk_phase;                  // Held only, not used here.
    logic master_en;                  // Master when set, else slave.
    logic port_en;                    // Block enable.
  } spx_ctrl_type;

  // Master sequencer states.
  typedef enum logic [1:0] {
    SPX_IDLE,
    SPX_ASSERT,
    SPX_SHIFT,
    SPX_STALL
  } spx_state_type;

endpackage

// file: design/spx_sync.sv
// Two-stage synchroniser for the serial pins.
// Assumes the inputs are asynchronous to the clock.
module spx_sync
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [3:0] i_async,
  output logic [3:0] o_sync
);

  // First stage, read only by the second stage.
  logic [3:0] meta;

  // ------------------------------------------------------------
  // Both stages.
  // ------------------------------------------------------------
  // Pins idle high through reset so no false edge is seen.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta <= 4'hF;
      o_sync <= 4'hF;
    end
    else
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// file: design/spx_fifo.sv
// Four-entry byte queue with registered head output.
// Assumes the user pops only when the count is non-zero.
`include "spx_defs.svh"

module spx_fifo
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_flush,
  input wire logic i_wr,
  input wire logic i_overwrite,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic [2:0] o_count
);

  logic [7:0] mem [4];     // Storage.
  logic [1:0] wptr;        // Next free slot.
  logic [1:0] rptr;        // Oldest entry.
  logic [7:0] next_rdata;  // Head value after this edge.
  logic push;              // Real append.
  logic pop;               // Real removal.

  assign push = i_wr & ~i_overwrite & (o_count != `SPX_FIFO_DEPTH);
  assign pop = i_rd & (o_count != 3'h0);

  // ------------------------------------------------------------
  // Head prediction.
  // ------------------------------------------------------------
  // A write into an empty queue bypasses the array so the head
  // register is valid on the very next cycle.
  always_comb
  begin
    next_rdata = pop ? mem[rptr + 2'h1] : mem[rptr];
    if (push && (o_count == (pop ? 3'h1 : 3'h0)))
      next_rdata = i_wdata;
  end

  // Storage write; an overwrite replaces the newest entry.
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wptr] <= i_wdata;
    else if (i_wr && i_overwrite)
      mem[wptr - 2'h1] <= i_wdata;
  end

  // Pointers and occupancy; a flush empties the queue at once.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wptr <= 2'h0;
      rptr <= 2'h0;
      o_count <= 3'h0;
      o_rdata <= 8'h00;
    end
    else if (i_flush)
    begin
      wptr <= 2'h0;
      rptr <= 2'h0;
      o_count <= 3'h0;
      o_rdata <= 8'h00;
    end
    else
    begin
      wptr <= wptr + (push ? 2'h1 : 2'h0);
      rptr <= rptr + (pop ? 2'h1 : 2'h0);
      o_count <= o_count + (push ? 3'h1 : 3'h0) - (pop ? 3'h1 : 3'h0);
      o_rdata <= (i_wr && i_overwrite && o_count == 3'h1) ? i_wdata
                 : next_rdata;
    end
  end

endmodule

// file: design/spx_top.sv
// Serial peripheral port with byte queues and APB registers.
// Assumes an APB master on I_CLK and asynchronous serial pins.
//
// Contract
// RULE1: Threshold code sets count one to four.
// RULE2: Top code raises receive interrupt when full.
// RULE3: Transmit purge flushes queue while held set.
// RULE4: Purge held sends last byte or zero.
// RULE5: Transmit writes ignored while purge is set.
// RULE6: Receive purge flushes queue while held set.
// RULE7: Receive purge drops bytes, no interrupts.
// RULE8: Purged receive read still starts a transfer.
// RULE9: Continuous master runs until transmit queue empty.
// RULE10: Select held low across continuous bytes.
// RULE11: Non-continuous transfer is one byte.
// RULE12: One serial clock gap before next byte.
// RULE13: Loopback feeds own output into receiver.
// RULE14: MISO open drain when drive bit clear.
// RULE15: Overrun replaces newest byte or discards new.
// RULE16: Zero fill sends zero on empty queue.
// RULE17: Otherwise empty queue repeats last byte.
// RULE18: Trigger selects write start or read start.
// RULE19: Overflow flags, interrupts, clears on status read.
// RULE20: Flush sets occupancy to zero.
`include "spx_defs.svh"

module spx_top
(
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_IRQ,
  input wire logic I_SCLK,
  output logic O_SCLK,
  output logic O_SCLK_OE,
  input wire logic I_MOSI,
  output logic O_MOSI,
  output logic O_MOSI_OE,
  input wire logic I_MISO,
  output logic O_MISO,
  output logic O_MISO_OE,
  input wire logic I_SS_N,
  output logic O_SS_N,
  output logic O_SS_N_OE
);

  // ------------------------------------------------------------
  // Declarations.
  // ------------------------------------------------------------
  spx_pkg::spx_ctrl_type ctrl;     // Control word.
  spx_pkg::spx_state_type state;   // Master sequencer state.
  logic [7:0] div;                 // Half serial period minus one.
  logic [3:0] pins;                // Synchronised serial inputs.
  logic sclk_s, mosi_s, miso_s, ss_n_s;
  logic sclk_d, ss_n_d;            // Previous synchronised levels.
  logic apb_act, wr_tx, rd_rx, rd_st;
  logic go;                        // Pending master start.
  logic [7:0] hcnt;                // Half period counter.
  logic phase;                     // Master clock half.
  logic ss_out;                    // Master select level.
  logic [7:0] sr;                  // Transmit shift register.
  logic [7:0] rxsr;                // Receive shift register.
  logic [2:0] bitcnt;              // Bit in the byte.
  logic [7:0] last_tx;             // Byte sent last.
  logic [7:0] tx_head, rx_head;
  logic [2:0] txc, rxc;            // Queue occupancy.
  logic [2:0] thr;                 // Threshold as a count.
  logic [2:0] tx_sent;             // Bytes sent since last irq.
  logic ovf, rxirq, txirq, txuf, isr;
  logic rx_chk;                    // Re-check receive level.
  logic tick, m_smp, m_trail, m_ld;
  logic s_act, s_lead, s_trail, s_ld;
  logic smp, trail, fin, ld, rx_bit;
  logic rx_full, rx_wr, tx_pop;
  logic ev_rx, ev_tx, ev_ovf, ev_uf;
  logic [7:0] tx_pick;             // Byte loaded on the next load.
  logic [31:0] status;

  assign {sclk_s, mosi_s, miso_s, ss_n_s} = pins;

  // Threshold code 00 to 11 means one to four bytes.
  assign thr = {1'b0, ctrl.irq_threshold_sel} + 3'h1;  // [RULE1]

  // ------------------------------------------------------------
  // Pin synchroniser and queues.
  // ------------------------------------------------------------
  spx_sync u_sync
  (
    .i_clk(I_CLK),
    .i_resetn(I_RESETN),
    .i_async({I_SCLK, I_MOSI, I_MISO, I_SS_N}),
    .o_sync(pins)
  );

  // Transmit queue; held flushed while purge is set.
  spx_fifo u_txq
  (
    .i_clk(I_CLK),
    .i_resetn(I_RESETN),
    .i_flush(ctrl.tx_queue_purge),   // [RULE3] [RULE20]
    .i_wr(wr_tx & ~ctrl.tx_queue_purge),   // [RULE5]
    .i_overwrite(1'b0),
    .i_wdata(I_PWDATA[7:0]),
    .i_rd(tx_pop),
    .o_rdata(tx_head),
    .o_count(txc)
  );

  // Receive queue; held flushed while purge is set.
  spx_fifo u_rxq
  (
    .i_clk(I_CLK),
    .i_resetn(I_RESETN),
    .i_flush(ctrl.rx_queue_purge),   // [RULE6] [RULE20]
    .i_wr(rx_wr),
    .i_overwrite(rx_full),
    .i_wdata(rxsr),
    .i_rd(rd_rx),
    .o_rdata(rx_head),
    .o_count(rxc)
  );

  // ------------------------------------------------------------
  // APB decode.
  // ------------------------------------------------------------
  // Side effects happen on the edge that raises PREADY, once per
  // access, because PREADY gates the access term.
  assign apb_act = I_PSEL & I_PENABLE & ~O_PREADY;
  assign wr_tx = apb_act & I_PWRITE & (I_PADDR == `SPX_OFS_TX);
  assign rd_rx = apb_act & ~I_PWRITE & (I_PADDR == `SPX_OFS_RX);
  assign rd_st = apb_act & ~I_PWRITE & (I_PADDR == `SPX_OFS_STATUS);

  assign status = {20'h0, (rxc > thr), rxc, ovf, rxirq, txirq, txuf,
                   txc, isr};

  // Bus answer: one wait state, read data and error from flops.
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end
    else
    begin
      O_PREADY <= apb_act;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
      if (apb_act)
      begin
        unique case (I_PADDR)
          `SPX_OFS_STATUS: O_PRDATA <= status;
          `SPX_OFS_RX: O_PRDATA <= {24'h0, rx_head};
          `SPX_OFS_TX: O_PRDATA <= 32'h0000_0000;
          `SPX_OFS_DIV: O_PRDATA <= {24'h0, div};
          `SPX_OFS_CTRL: O_PRDATA <= {16'h0, ctrl};
          default: O_PSLVERR <= 1'b1;  // Unmapped address.
        endcase
      end
    end
  end

  // Writable configuration registers.
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      ctrl <= `SPX_CTRL_RST;
      div <= `SPX_DIV_RST;
    end
    else if (apb_act && I_PWRITE)
    begin
      if (I_PADDR == `SPX_OFS_CTRL)
        ctrl <= I_PWDATA[15:0];
      if (I_PADDR == `SPX_OFS_DIV)
        div <= I_PWDATA[7:0];
    end
  end

  // ------------------------------------------------------------
  // Master sequencer.
  // ------------------------------------------------------------
  assign tick = (hcnt == div);
  assign m_smp = (state == spx_pkg::SPX_SHIFT) & tick & ~phase;
  assign m_trail = (state == spx_pkg::SPX_SHIFT) & tick & phase;
  // A continuous run reloads straight after the last bit.
  assign m_ld = ((state == spx_pkg::SPX_ASSERT) & tick) |
                (m_trail & (bitcnt == `SPX_LAST_BIT) &
                 ctrl.back_to_back_xfer & (txc != 3'h0));  // [RULE9]

  // Start request: a data write or a data read, by trigger mode.
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      go <= 1'b0;
    else if (ctrl.xfer_trigger_sel ? wr_tx : rd_rx)  // [RULE18] [RULE8]
      go <= 1'b1;
    // A write taken during a continuous run is carried by that run,
    // so it must not start a stray frame once the run has ended.
    else if (state == spx_pkg::SPX_ASSERT || !ctrl.master_en ||
             (state != spx_pkg::SPX_IDLE && ctrl.back_to_back_xfer &&
              ctrl.xfer_trigger_sel))  // [RULE9]
      go <= 1'b0;
  end

  // Select stays low from start through every continuous byte and
  // rises only when the queue runs dry or the byte was a single one.
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      state <= spx_pkg::SPX_IDLE;
      hcnt <= 8'h00;
      phase <= 1'b0;
      ss_out <= 1'b1;
    end
    else if (!(ctrl.port_en && ctrl.master_en))
    begin
      state <= spx_pkg::SPX_IDLE;
      hcnt <= 8'h00;
      phase <= 1'b0;
      ss_out <= 1'b1;
    end
    else
    begin
      hcnt <= tick ? 8'h00 : hcnt + 8'h01;
      unique case (state)
        spx_pkg::SPX_IDLE:
        begin
          hcnt <= 8'h00;
          if (go)
          begin
            state <= spx_pkg::SPX_ASSERT;
            ss_out <= 1'b0;                       // [RULE10]
          end
        end
        spx_pkg::SPX_ASSERT:
        begin
          if (tick)
          begin
            state <= spx_pkg::SPX_SHIFT;
            phase <= 1'b0;
          end
        end
        spx_pkg::SPX_SHIFT:
        begin
          if (tick)
            phase <= ~phase;
          if (m_trail && bitcnt == `SPX_LAST_BIT)
          begin
            if (ctrl.back_to_back_xfer && txc != 3'h0)
              state <= spx_pkg::SPX_SHIFT;        // [RULE9] [RULE10]
            else if (!ctrl.back_to_back_xfer && txc != 3'h0 &&
                     ctrl.xfer_trigger_sel)
            begin
              state <= spx_pkg::SPX_STALL;        // [RULE12]
              ss_out <= 1'b1;
            end
            else
            begin
              state <= spx_pkg::SPX_IDLE;         // [RULE11]
              ss_out <= 1'b1;
            end
          end
        end
        spx_pkg::SPX_STALL:
        begin
          // Two half periods make one idle serial clock cycle.
          if (tick)
            phase <= ~phase;
          if (tick && phase)
          begin
            state <= spx_pkg::SPX_ASSERT;         // [RULE12]
            ss_out <= 1'b0;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Slave edge detection.
  // ------------------------------------------------------------
  // Only the second synchroniser stage feeds these edge detectors.
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      sclk_d <= 1'b0;
      ss_n_d <= 1'b1;
    end
    else
    begin
      sclk_d <= sclk_s ^ ctrl.clk_idle_high;
      ss_n_d <= ss_n_s;
    end
  end

  assign s_act = ctrl.port_en & ~ctrl.master_en & ~ss_n_s;
  assign s_lead = s_act & (sclk_s ^ ctrl.clk_idle_high) & ~sclk_d;
  assign s_trail = s_act & ~(sclk_s ^ ctrl.clk_idle_high) & sclk_d;
  assign s_ld = (s_act & ss_n_d) |
                (s_trail & (bitcnt == `SPX_LAST_BIT));

  // ------------------------------------------------------------
  // Shared shift datapath.
  // ------------------------------------------------------------
  assign smp = m_smp | s_lead;
  assign trail = m_trail | s_trail;
  assign fin = trail & (bitcnt == `SPX_LAST_BIT);
  assign ld = m_ld | s_ld;
  assign tx_pop = ld & ~ctrl.tx_queue_purge;

  // Loopback takes the receive bit from our own output.
  assign rx_bit = ctrl.internal_loopback_en ? sr[7] :   // [RULE13]
                  (ctrl.master_en ? miso_s : mosi_s);

  // Empty or purged queue: zero or a repeat of the last byte.
  assign tx_pick = (txc != 3'h0 && !ctrl.tx_queue_purge) ? tx_head :
                   (ctrl.idle_zero_fill ? `SPX_FILL_ZERO :  // [RULE16]
                    last_tx);                  // [RULE4] [RULE17]

  // Bits go out most significant first on the trailing edge.
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      sr <= 8'h00;
      rxsr <= 8'h00;
      bitcnt <= 3'h0;
      last_tx <= 8'h00;
    end
    else
    begin
      if (smp)
        rxsr <= {rxsr[6:0], rx_bit};
      if (ld)
      begin
        sr <= tx_pick;
        last_tx <= tx_pick;
        bitcnt <= 3'h0;
      end
      else if (trail)
      begin
        sr <= {sr[6:0], 1'b0};
        bitcnt <= bitcnt + 3'h1;
      end
      else if (!s_act && !ctrl.master_en)
        bitcnt <= 3'h0;
    end
  end

  // ------------------------------------------------------------
  // Receive acceptance and event flags.
  // ------------------------------------------------------------
  assign rx_full = (rxc == `SPX_FIFO_DEPTH);
  // Purge drops every byte; a full queue takes it only as a
  // replacement of the newest entry.
  assign rx_wr = fin & ~ctrl.rx_queue_purge &                 // [RULE7]
                 (~rx_full | ctrl.rx_overrun_replace);       // [RULE15]
  assign ev_ovf = fin & rx_full & ~ctrl.rx_queue_purge;      // [RULE19]
  assign ev_uf = ld & (txc == 3'h0) & ~ctrl.tx_queue_purge;
  // Level check one cycle after a write sees the updated count.
  assign ev_rx = rx_chk & ~ctrl.xfer_trigger_sel &
                 (rxc >= thr) & ~ctrl.rx_queue_purge;   // [RULE1] [RULE2]
  assign ev_tx = fin & ctrl.xfer_trigger_sel &
                 (tx_sent + 3'h1 >= thr);                   // [RULE1]

  // Transmitted byte counter toward the transmit threshold.
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      tx_sent <= 3'h0;
      rx_chk <= 1'b0;
    end
    else
    begin
      rx_chk <= rx_wr;
      if (ev_tx)
        tx_sent <= 3'h0;
      else if (fin)
        tx_sent <= tx_sent + 3'h1;
    end
  end

  // Sticky flags; a status read clears them but a same-cycle
  // event wins, so no event is lost. Receive purge masks all events from isr.
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      ovf <= 1'b0;
      rxirq <= 1'b0;
      txirq <= 1'b0;
      txuf <= 1'b0;
      isr <= 1'b0;
    end
    else
    begin
      ovf <= ev_ovf | (ovf & ~rd_st);                        // [RULE19]
      rxirq <= ev_rx | (rxirq & ~rd_st);
      txirq <= ev_tx | (txirq & ~rd_st);
      txuf <= ev_uf | (txuf & ~rd_st);
      isr <= (~ctrl.rx_queue_purge & (ev_ovf | ev_rx | ev_tx | ev_uf))
             | (isr & ~rd_st);                               // [RULE7]
    end
  end

  // ------------------------------------------------------------
  // Registered outputs.
  // ------------------------------------------------------------
  // MISO drives only low when its drive bit is off, so the pin acts
  // as open drain with an external pull-up.
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_IRQ <= 1'b0;
      O_SCLK <= 1'b0;
      O_SCLK_OE <= 1'b0;
      O_MOSI <= 1'b0;
      O_MOSI_OE <= 1'b0;
      O_MISO <= 1'b0;
      O_MISO_OE <= 1'b0;
      O_SS_N <= 1'b1;
      O_SS_N_OE <= 1'b0;
    end
    else
    begin
      O_IRQ <= isr;
      O_SCLK <= (phase & (state == spx_pkg::SPX_SHIFT)) ^ ctrl.clk_idle_high;
      O_SCLK_OE <= ctrl.port_en & ctrl.master_en;
      O_MOSI <= sr[7];
      O_MOSI_OE <= ctrl.port_en & ctrl.master_en;
      O_MISO <= sr[7];
      O_MISO_OE <= s_act & (ctrl.miso_drive_en | ~sr[7]);   // [RULE14]
      O_SS_N <= ss_out;
      O_SS_N_OE <= ctrl.port_en & ctrl.master_en;
    end
  end

endmodule

// file: tb/spx_partner.sv
// Remote serial slave model: takes MOSI bytes, answers A5.
// Assumes mode 0 framing, MSB first, select active low.
module spx_partner
(
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_ss_n,
  output logic o_miso,
  output logic [7:0] o_got,
  output int o_nb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx = 8'h00; // Incoming bits.
  logic [7:0] tx = 8'hA5; // Reply, MSB on the line.
  logic [2:0] bits = 3'h0; // Bits of this byte.
  logic last = 1'b0; // Last bit put on the line.
  initial o_got = 8'h00;
  initial o_nb = 0;
  // Unselected, the line shows the inverse of its last value.
  assign o_miso = i_ss_n ? ~last : tx[7];
  // A new frame reloads the reply and the bit count.
  always @(negedge i_ss_n)
  begin
    tx = 8'hA5;
    bits = 3'h0;
  end
  // Sample on the leading edge; eight bits make a byte.
  always @(posedge i_sclk)
  begin
    if (!i_ss_n)
    begin
      rx = {rx[6:0], i_mosi};
      bits = bits + 3'h1;
      last = tx[7];
      if (bits == 3'h0)
      begin
        o_got = rx;
        o_nb = o_nb + 1;
      end
    end
  end
  // Next reply bit on the trailing edge.
  always @(negedge i_sclk)
    if (!i_ss_n)
      tx = {tx[6:0], 1'b0};
endmodule

// file: tb/spx_checker.sv
// Port checks of the serial port block.
// Assumes it is bound into spx_top and sees its ports only.
module spx_checker
(
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_SCLK,
  input wire logic O_SS_N
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  logic sclk_q; // Clock level one cycle ago.
  logic ss_q; // Select level one cycle ago.
  logic [7:0] edges; // Clock edges since select fell.
  // Count edges per frame; a frame must hold whole bytes.
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      sclk_q <= 1'b0;
      ss_q <= 1'b1;
      edges <= 8'h00;
    end
    else
    begin
      sclk_q <= O_SCLK;
      ss_q <= O_SS_N;
      if (ss_q && !O_SS_N)
        edges <= 8'h00;
      else if (O_SCLK != sclk_q)
        edges <= edges + 8'h01;
    end
  end
  sequence s_access;
    I_PSEL && I_PENABLE && !O_PREADY;
  endsequence
  sequence s_frame_end;
    $rose(O_SS_N);
  endsequence
  a_ready_follows: assert property (s_access |=> O_PREADY)
    else $error("ready missing after access");
  a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property
    (O_PREADY |-> $past(I_PSEL) && $past(I_PENABLE))
    else $error("ready without access");
  a_err_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error outside ready");
  a_rdata_quiet: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
    else $error("read data outside ready");
  a_err_mapped: assert property (O_PREADY && $past(I_PADDR) <= 8'h10
    && ($past(I_PADDR) & 8'h03) == 8'h00 |-> !O_PSLVERR)
    else $error("error on mapped address");
  a_byte_whole: assert property (s_frame_end |=>
    edges != 8'h00 && edges[3:0] == 4'h0)
    else $error("frame not whole bytes");
  a_stall_gap: assert property (s_frame_end |-> O_SS_N [*2])
    else $error("select gap too short");
endmodule
bind spx_top spx_checker spx_checker_inst (.I_CLK, .I_RESETN, .I_PSEL,
  .I_PENABLE, .I_PADDR, .O_PRDATA, .O_PREADY, .O_PSLVERR, .O_SCLK,
  .O_SS_N);

// file: tb/spx_top_tb.sv
// Bench: APB tasks drive the serial port against a slave model.
// Assumes design, partner and checker are compiled first.
`include "spx_defs.svh"
module spx_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, psel, pen, pwr, e, ss_q, rdy, err, irq, mi_p;
  logic sck, sck_oe, mo, mo_oe, mi, mi_oe, ss, ss_oe;
  logic [7:0] paddr, got;
  logic [31:0] pwdata, prdata, q;
  int n_fail, checked, cyc, nb, rises, r0;
  // Released lines rest at their pull level; released MISO shows the partner.
  wire sck_w = sck_oe ? sck : 1'b0;
  wire mo_w = mo_oe ? mo : 1'b1;
  wire ss_w = ss_oe ? ss : 1'b1;
  wire mi_w = mi_oe ? mi : mi_p;
  spx_top spx_top_inst (.I_CLK(clk), .I_RESETN(rstn), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(rdy),
    .O_PSLVERR(err), .O_IRQ(irq), .I_SCLK(sck_w), .O_SCLK(sck),
    .O_SCLK_OE(sck_oe), .I_MOSI(mo_w), .O_MOSI(mo), .O_MOSI_OE(mo_oe),
    .I_MISO(mi_w), .O_MISO(mi), .O_MISO_OE(mi_oe), .I_SS_N(ss_w),
    .O_SS_N(ss), .O_SS_N_OE(ss_oe));
  spx_partner spx_partner_inst (.i_sclk(sck_w), .i_mosi(mo_w),
    .i_ss_n(ss_w), .o_miso(mi_p), .o_got(got), .o_nb(nb));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Count frames and cut a hang short; tests need under a thousand.
  always @(posedge clk)
  begin
    if (ss_w && !ss_q)
      rises = rises + 1;
    ss_q = ss_w;
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      wrap_up();
    end
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; the request holds until ready is sampled.
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    q = prdata;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Wait until the slave holds n bytes and select is back high.
  task automatic xfer(int n);
    while (nb < n) @(posedge clk);
    while (ss_w !== 1'b1) @(posedge clk);
    @(posedge clk); // Let the frame counter see the rise.
  endtask
  initial
  begin
    {rstn, psel, pen, pwr, paddr, pwdata, ss_q} = '0;
    {n_fail, checked, cyc, rises} = '0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, `SPX_OFS_CTRL, 32'h0);
    chk("ctrl reset", q[15:0], 16'h0000);
    apb(1'b0, `SPX_OFS_DIV, 32'h0);
    chk("div reset", q[15:0], 16'h0000);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped error", e, 1'b1);
    wr(`SPX_OFS_DIV, 32'h3); // Serial period of eight clocks.
    wr(`SPX_OFS_CTRL, 32'h0043);
    wr(`SPX_OFS_TX, 32'h3C);
    xfer(1);
    chk("tx byte", got, 8'h3C);
    apb(1'b0, `SPX_OFS_RX, 32'h0);
    chk("rx byte", q[7:0], 8'hA5);
    wr(`SPX_OFS_CTRL, 32'h0843);
    r0 = rises;
    wr(`SPX_OFS_TX, 32'h11);
    wr(`SPX_OFS_TX, 32'h22);
    wr(`SPX_OFS_TX, 32'h33);
    xfer(4);
    chk("burst end", got, 8'h33);
    chk("burst frames", rises - r0, 1);
    wr(`SPX_OFS_CTRL, 32'h0043);
    r0 = rises;
    wr(`SPX_OFS_TX, 32'h44);
    wr(`SPX_OFS_TX, 32'h55);
    xfer(6);
    chk("single frames", rises - r0, 2);
    chk("irq set", irq, 1'b1);
    apb(1'b0, `SPX_OFS_STATUS, 32'h0);
    chk("flags", q[15:0], 16'h0CA1);
    wr(`SPX_OFS_CTRL, 32'h3003);
    wr(`SPX_OFS_TX, 32'h77);
    apb(1'b0, `SPX_OFS_STATUS, 32'h0);
    chk("purged counts", q[10:1], 10'h000);
    apb(1'b0, `SPX_OFS_RX, 32'h0);
    xfer(7);
    chk("repeat byte", got, 8'h55);
    chk("irq quiet", irq, 1'b0);
    wr(`SPX_OFS_CTRL, 32'h3083);
    apb(1'b0, `SPX_OFS_RX, 32'h0);
    xfer(8);
    chk("zero byte", got, 8'h00);
    apb(1'b0, `SPX_OFS_STATUS, 32'h0);
    chk("dropped rx", q[10:8], 3'h0);
    wr(`SPX_OFS_CTRL, 32'h0443);
    wr(`SPX_OFS_TX, 32'h96);
    xfer(9);
    apb(1'b0, `SPX_OFS_RX, 32'h0);
    chk("loopback", q[7:0], 8'h96);
    wrap_up();
  end
endmodule
